/* common/sdocr_pkg.sv */
// constants of the synthesizer configuration register bank
// assumes 32-bit AXI4-Lite data, one register per aligned word
package sdocr_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] SDOCR_IDX_FB_INT_HIGH = 6'h22;
   localparam logic [5:0] SDOCR_IDX_FB_INT_LOW = 6'h24;
   localparam logic [5:0] SDOCR_IDX_SEED_EN_DLY = 6'h25;
   localparam logic [5:0] SDOCR_IDX_DEN_HIGH = 6'h26;
   localparam logic [5:0] SDOCR_IDX_DEN_LOW = 6'h27;
   localparam logic [5:0] SDOCR_IDX_SEED_HIGH = 6'h28;
   localparam logic [5:0] SDOCR_IDX_SEED_LOW = 6'h29;
   localparam logic [5:0] SDOCR_IDX_NUM_HIGH = 6'h2a;
   localparam logic [5:0] SDOCR_IDX_NUM_LOW = 6'h2b;
   localparam logic [5:0] SDOCR_IDX_OUTA_MOD = 6'h2c;
   localparam logic [5:0] SDOCR_IDX_OUTA_SRC_B_PWR = 6'h2d;
   localparam logic [5:0] SDOCR_IDX_OUTB_SRC = 6'h2e;
   localparam logic [5:0] SDOCR_IDX_INPUT_PIN = 6'h3a;
   localparam logic [5:0] SDOCR_IDX_LOCK_TYPE = 6'h3b;
   localparam logic [5:0] SDOCR_IDX_LOCK_DELAY = 6'h3c;

   // ------------------------------------------------------------
   // storage slots, seed words kept apart as an accumulator
   // ------------------------------------------------------------
   localparam int SDOCR_SLOTS = 13;
   localparam logic [3:0] SDOCR_SLOT_FB_HIGH = 4'h0;
   localparam logic [3:0] SDOCR_SLOT_FB_LOW = 4'h1;
   localparam logic [3:0] SDOCR_SLOT_SEED_DLY = 4'h2;
   localparam logic [3:0] SDOCR_SLOT_DEN_HIGH = 4'h3;
   localparam logic [3:0] SDOCR_SLOT_DEN_LOW = 4'h4;
   localparam logic [3:0] SDOCR_SLOT_NUM_HIGH = 4'h5;
   localparam logic [3:0] SDOCR_SLOT_NUM_LOW = 4'h6;
   localparam logic [3:0] SDOCR_SLOT_OUTA_MOD = 4'h7;
   localparam logic [3:0] SDOCR_SLOT_OUTA_SRC = 4'h8;
   localparam logic [3:0] SDOCR_SLOT_OUTB_SRC = 4'h9;
   localparam logic [3:0] SDOCR_SLOT_INPUT_PIN = 4'ha;
   localparam logic [3:0] SDOCR_SLOT_LOCK_TYPE = 4'hb;
   localparam logic [3:0] SDOCR_SLOT_LOCK_DELAY = 4'hc;
   localparam logic [3:0] SDOCR_NO_SLOT = 4'hf;

   // reset images, slot 12 first
   localparam logic [SDOCR_SLOTS-1:0][15:0] SDOCR_RESET = {
      16'h03e8, 16'h0001, 16'h8001, 16'h07fd, 16'hc8df, 16'h1fa0, 16'h0000,
      16'h0000, 16'hffff, 16'hffff, 16'h0204, 16'h0064, 16'h0000};
   // writable bits, slot 12 first; other bits hold their reset image
   localparam logic [SDOCR_SLOTS-1:0][15:0] SDOCR_MASK = {
      16'hffff, 16'h0001, 16'hfe00, 16'h0003, 16'h1e3f, 16'h3fe7, 16'hffff,
      16'hffff, 16'hffff, 16'hffff, 16'hbf00, 16'hffff, 16'h0007};

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SDOCR_FB_HIGH_W = 3;
   localparam int SDOCR_SEED_EN_BIT = 15;
   localparam int SDOCR_DLY_LSB = 8;
   localparam int SDOCR_DLY_W = 6;
   localparam int SDOCR_OUT_A_POWER_LEVEL_LSB = 8;
   localparam int SDOCR_PWR_W = 6;
   localparam int SDOCR_OUT_B_POWERDOWN_BIT = 7;
   localparam int SDOCR_OUT_A_POWERDOWN_BIT = 6;
   localparam int SDOCR_MOD_RESET_BIT = 5;
   localparam int SDOCR_ORDER_LSB = 0;
   localparam int SDOCR_ORDER_W = 3;
   localparam int SDOCR_OUTA_SRC_LSB = 11;
   localparam int SDOCR_BOOST_LSB = 9;
   localparam int SDOCR_OUT_B_POWER_LEVEL_LSB = 0;
   localparam int SDOCR_OUTB_SRC_LSB = 0;
   localparam int SDOCR_IGNORE_BIT = 15;
   localparam int SDOCR_HYST_BIT = 14;
   localparam int SDOCR_LVL_LSB = 12;
   localparam int SDOCR_FMT_LSB = 9;
   localparam int SDOCR_FMT_W = 3;
   localparam int SDOCR_KIND_BIT = 0;

   // ------------------------------------------------------------
   // codes
   // ------------------------------------------------------------
   localparam logic [1:0] SDOCR_SRC_FRAME_REF = 2'h2;
   localparam logic [1:0] SDOCR_SRC_HIGH_Z = 2'h3;
   localparam logic [2:0] SDOCR_ORDER_INTEGER = 3'h0;
   localparam logic [2:0] SDOCR_ORDER_MAX = 3'h4;
   localparam logic [1:0] SDOCR_LVL_INVALID = 2'h3;
   localparam logic [1:0] SDOCR_LVL_FULL = 2'h1;
   localparam logic [2:0] SDOCR_FMT_MAX = 3'h3;
   localparam logic [2:0] SDOCR_FMT_CMOS = 3'h0;
   localparam logic [1:0] SDOCR_RESP_OKAY = 2'h0;
   localparam logic [1:0] SDOCR_RESP_SLVERR = 2'h2;

   // register index to storage slot
   function automatic logic [3:0] sdocr_slot_of(input logic [5:0] idx);
      case (idx)
         SDOCR_IDX_FB_INT_HIGH: sdocr_slot_of = SDOCR_SLOT_FB_HIGH;
         SDOCR_IDX_FB_INT_LOW: sdocr_slot_of = SDOCR_SLOT_FB_LOW;
         SDOCR_IDX_SEED_EN_DLY: sdocr_slot_of = SDOCR_SLOT_SEED_DLY;
         SDOCR_IDX_DEN_HIGH: sdocr_slot_of = SDOCR_SLOT_DEN_HIGH;
         SDOCR_IDX_DEN_LOW: sdocr_slot_of = SDOCR_SLOT_DEN_LOW;
         SDOCR_IDX_NUM_HIGH: sdocr_slot_of = SDOCR_SLOT_NUM_HIGH;
         SDOCR_IDX_NUM_LOW: sdocr_slot_of = SDOCR_SLOT_NUM_LOW;
         SDOCR_IDX_OUTA_MOD: sdocr_slot_of = SDOCR_SLOT_OUTA_MOD;
         SDOCR_IDX_OUTA_SRC_B_PWR: sdocr_slot_of = SDOCR_SLOT_OUTA_SRC;
         SDOCR_IDX_OUTB_SRC: sdocr_slot_of = SDOCR_SLOT_OUTB_SRC;
         SDOCR_IDX_INPUT_PIN: sdocr_slot_of = SDOCR_SLOT_INPUT_PIN;
         SDOCR_IDX_LOCK_TYPE: sdocr_slot_of = SDOCR_SLOT_LOCK_TYPE;
         SDOCR_IDX_LOCK_DELAY: sdocr_slot_of = SDOCR_SLOT_LOCK_DELAY;
         default: sdocr_slot_of = SDOCR_NO_SLOT;
      endcase
   endfunction

endpackage

/* hw/sdocr_lock_timer.sv */
// lock indication timer: waits a programmed number of detector ticks
// assumes pd_tick is a one-cycle pulse per phase-detector cycle
`timescale 1ns/1ns
module sdocr_lock_timer (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // lock sources
   input wire logic cal_ok,
   input wire logic tune_ok,
   input wire logic pd_tick,
   // settings
   input wire logic kind,
   input wire logic [15:0] wait_ticks,
   // result
   output logic lock
);

   typedef enum logic [1:0] {
      SDOCR_LK_IDLE,
      SDOCR_LK_WAIT,
      SDOCR_LK_LOCKED
   } sdocr_lock_state_t;

   typedef struct packed {
      sdocr_lock_state_t fsm;
      logic [15:0] count;
      logic lock;
   } sdocr_lock_t;

   sdocr_lock_t st;
   sdocr_lock_t next_st;
   logic good;

   always_comb begin
      next_st = st;
      good = cal_ok && (!kind || tune_ok);
      if (reset) begin
         next_st.fsm = SDOCR_LK_IDLE;
         next_st.count = 16'h0000;
      end else if (!good) begin
         next_st.fsm = SDOCR_LK_IDLE;
         next_st.count = 16'h0000;
      end else begin
         case (st.fsm)
            SDOCR_LK_IDLE: begin
               next_st.count = 16'h0000;
               if (wait_ticks == 16'h0000) begin
                  next_st.fsm = SDOCR_LK_LOCKED;
               end else begin
                  next_st.fsm = SDOCR_LK_WAIT;
               end
            end
            SDOCR_LK_WAIT: begin
               if (pd_tick) begin
                  next_st.count = st.count + 16'h0001;
                  if (st.count + 16'h0001 >= wait_ticks) begin
                     next_st.fsm = SDOCR_LK_LOCKED;
                  end
               end
            end
            SDOCR_LK_LOCKED: begin
               next_st.fsm = SDOCR_LK_LOCKED;
            end
            default: begin
               next_st.fsm = SDOCR_LK_IDLE;
            end
         endcase
      end
      next_st.lock = (next_st.fsm == SDOCR_LK_LOCKED);
   end

   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign lock = st.lock;

endmodule

/* hw/sdocr_regs.sv */
// synthesizer divider, modulator, output and input-pin configuration bank
// assumes an AXI4-Lite master on SYS_CLK and synchronous pin inputs
`timescale 1ns/1ns

module sdocr_regs (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // axi4-lite write address
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // divider and modulator
   output logic [18:0] FEEDBACK_INT,
   output logic [5:0] DETECTOR_DELAY_SELECT,
   output logic [31:0] FRACTION_NUMERATOR,
   output logic [31:0] FRACTION_DENOMINATOR,
   output logic [31:0] MODULATOR_SEED,
   output logic MODULATOR_RUN,
   output logic [2:0] MODULATOR_ORDER,
   // rf outputs
   input wire logic FRAME_REF_ENABLE,
   output logic [5:0] OUT_A_POWER_LEVEL,
   output logic OUT_A_POWERDOWN,
   output logic [1:0] OUT_A_SOURCE_SELECT,
   output logic OUT_A_HIGH_Z,
   output logic [1:0] OUTPUT_CURRENT_BOOST,
   output logic [5:0] OUT_B_POWER_LEVEL,
   output logic OUT_B_POWERDOWN,
   output logic [1:0] OUT_B_SOURCE_SELECT,
   output logic OUT_B_HIGH_Z,
   // input pins
   input wire logic OSCILLATOR_PHASE_ALIGN,
   input wire logic SYNC_PIN,
   input wire logic FRAME_REF_REQUEST_PIN,
   output logic SYNC_PIN_USED,
   output logic FRAME_REF_REQUEST_USED,
   output logic SYNC_LVDS,
   output logic REQUEST_LVDS,
   output logic INPUT_PIN_HYSTERESIS,
   output logic [1:0] INPUT_PIN_BIAS_LEVEL,
   // lock indication
   input wire logic CAL_SUCCESS,
   input wire logic TUNE_IN_RANGE,
   input wire logic PD_TICK,
   output logic LOCK_DETECT
);

   typedef struct packed {
      logic [sdocr_pkg::SDOCR_SLOTS-1:0][15:0] regs;
      logic [31:0] seed;
      logic aw_held;
      logic [5:0] aw_idx;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic aw_rdy;
      logic w_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [18:0] fb_int;
      logic [5:0] dly_sel;
      logic [31:0] num;
      logic [31:0] den;
      logic [31:0] seed_out;
      logic mod_run;
      logic [2:0] order;
      logic [5:0] a_pwr;
      logic a_pd;
      logic [1:0] a_src;
      logic a_hiz;
      logic [1:0] boost;
      logic [5:0] b_pwr;
      logic b_pd;
      logic [1:0] b_src;
      logic b_hiz;
      logic sync_used;
      logic req_used;
      logic sync_lvds;
      logic req_lvds;
      logic hyst;
      logic [1:0] lvl;
   } sdocr_state_t;

   sdocr_state_t st;
   sdocr_state_t next_st;
   logic [3:0] wr_slot;
   logic [3:0] rd_slot;
   logic [15:0] byte_mask;
   logic [15:0] addend;
   logic [15:0] merged;
   logic [15:0] rd_word;
   logic [2:0] fmt;
   logic [15:0] r_seed;
   logic [15:0] r_mod;
   logic [15:0] r_src;
   logic [15:0] r_pin;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      wr_slot = sdocr_pkg::sdocr_slot_of(st.aw_idx);
      rd_slot = sdocr_pkg::sdocr_slot_of(S_AXI_ARADDR[7:2]);
      byte_mask = {{8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
      addend = st.w_data & byte_mask;
      merged = 16'h0000;
      rd_word = 16'h0000;
      if (RESET) begin
         next_st.regs = sdocr_pkg::SDOCR_RESET;
         next_st.seed = 32'h00000000;
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.aw_rdy = 1'b0;
         next_st.w_rdy = 1'b0;
         next_st.bvalid = 1'b0;
         next_st.bresp = sdocr_pkg::SDOCR_RESP_OKAY;
         next_st.ar_rdy = 1'b0;
         next_st.rvalid = 1'b0;
         next_st.rresp = sdocr_pkg::SDOCR_RESP_OKAY;
         next_st.rdata = 32'h00000000;
      end else begin
         // address and data are taken independently
         if (S_AXI_AWVALID && st.aw_rdy) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = S_AXI_AWADDR[7:2];
         end
         if (S_AXI_WVALID && st.w_rdy) begin
            next_st.w_held = 1'b1;
            next_st.w_data = S_AXI_WDATA[15:0];
            next_st.w_strb = S_AXI_WSTRB[1:0];
         end
         if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid = 1'b0;
         end
         if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = sdocr_pkg::SDOCR_RESP_OKAY;
            if (wr_slot != sdocr_pkg::SDOCR_NO_SLOT) begin
               merged = (st.regs[wr_slot] & ~byte_mask) | (st.w_data & byte_mask);
               next_st.regs[wr_slot] = (merged & sdocr_pkg::SDOCR_MASK[wr_slot])
                  | (sdocr_pkg::SDOCR_RESET[wr_slot] & ~sdocr_pkg::SDOCR_MASK[wr_slot]);
            end else if (st.aw_idx == sdocr_pkg::SDOCR_IDX_SEED_HIGH) begin
               next_st.seed = st.seed + {addend, 16'h0000};
            end else if (st.aw_idx == sdocr_pkg::SDOCR_IDX_SEED_LOW) begin
               next_st.seed = st.seed + {16'h0000, addend};
            end else begin
               next_st.bresp = sdocr_pkg::SDOCR_RESP_SLVERR;
            end
         end
         // read side
         if (st.rvalid && S_AXI_RREADY) begin
            next_st.rvalid = 1'b0;
         end
         if (S_AXI_ARVALID && st.ar_rdy) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = sdocr_pkg::SDOCR_RESP_OKAY;
            if (rd_slot != sdocr_pkg::SDOCR_NO_SLOT) begin
               rd_word = st.regs[rd_slot];
            end else if (S_AXI_ARADDR[7:2] == sdocr_pkg::SDOCR_IDX_SEED_HIGH) begin
               rd_word = st.seed[31:16];
            end else if (S_AXI_ARADDR[7:2] == sdocr_pkg::SDOCR_IDX_SEED_LOW) begin
               rd_word = st.seed[15:0];
            end else begin
               next_st.rresp = sdocr_pkg::SDOCR_RESP_SLVERR;
            end
            next_st.rdata = {16'h0000, rd_word};
         end
         next_st.aw_rdy = !next_st.aw_held && !next_st.bvalid;
         next_st.w_rdy = !next_st.w_held && !next_st.bvalid;
         next_st.ar_rdy = !next_st.rvalid;
      end

      r_seed = next_st.regs[sdocr_pkg::SDOCR_SLOT_SEED_DLY];
      r_mod = next_st.regs[sdocr_pkg::SDOCR_SLOT_OUTA_MOD];
      r_src = next_st.regs[sdocr_pkg::SDOCR_SLOT_OUTA_SRC];
      r_pin = next_st.regs[sdocr_pkg::SDOCR_SLOT_INPUT_PIN];

      // modulator held in reset keeps the accumulated seed at zero
      next_st.mod_run = r_mod[sdocr_pkg::SDOCR_MOD_RESET_BIT];
      if (!next_st.mod_run) begin
         next_st.seed = 32'h00000000;
      end

      // ------------------------------------------------------------
      // decoded outputs
      // ------------------------------------------------------------
      next_st.fb_int = {next_st.regs[sdocr_pkg::SDOCR_SLOT_FB_HIGH]
         [sdocr_pkg::SDOCR_FB_HIGH_W-1:0], next_st.regs[sdocr_pkg::SDOCR_SLOT_FB_LOW]};
      next_st.dly_sel = r_seed[sdocr_pkg::SDOCR_DLY_LSB +: sdocr_pkg::SDOCR_DLY_W];
      next_st.order = r_mod[sdocr_pkg::SDOCR_ORDER_LSB +: sdocr_pkg::SDOCR_ORDER_W];
      if (!next_st.mod_run || next_st.order > sdocr_pkg::SDOCR_ORDER_MAX) begin
         next_st.order = sdocr_pkg::SDOCR_ORDER_INTEGER;
      end
      if (next_st.mod_run) begin
         next_st.num = {next_st.regs[sdocr_pkg::SDOCR_SLOT_NUM_HIGH],
            next_st.regs[sdocr_pkg::SDOCR_SLOT_NUM_LOW]};
         next_st.den = {next_st.regs[sdocr_pkg::SDOCR_SLOT_DEN_HIGH],
            next_st.regs[sdocr_pkg::SDOCR_SLOT_DEN_LOW]};
      end else begin
         next_st.num = 32'h00000000;
         next_st.den = 32'h00000000;
      end
      next_st.seed_out = r_seed[sdocr_pkg::SDOCR_SEED_EN_BIT] ? next_st.seed : 32'h00000000;

      next_st.a_pwr = r_mod[sdocr_pkg::SDOCR_OUT_A_POWER_LEVEL_LSB +: sdocr_pkg::SDOCR_PWR_W];
      next_st.b_pd = r_mod[sdocr_pkg::SDOCR_OUT_B_POWERDOWN_BIT];
      next_st.a_pd = r_mod[sdocr_pkg::SDOCR_OUT_A_POWERDOWN_BIT];
      next_st.a_src = r_src[sdocr_pkg::SDOCR_OUTA_SRC_LSB +: 2];
      next_st.a_hiz = (next_st.a_src == sdocr_pkg::SDOCR_SRC_HIGH_Z);
      next_st.boost = r_src[sdocr_pkg::SDOCR_BOOST_LSB +: 2];
      next_st.b_pwr = r_src[sdocr_pkg::SDOCR_OUT_B_POWER_LEVEL_LSB +: sdocr_pkg::SDOCR_PWR_W];
      next_st.b_src = next_st.regs[sdocr_pkg::SDOCR_SLOT_OUTB_SRC]
         [sdocr_pkg::SDOCR_OUTB_SRC_LSB +: 2];
      // output B frame reference source without its enable falls back to high impedance
      next_st.b_hiz = (next_st.b_src == sdocr_pkg::SDOCR_SRC_HIGH_Z)
         || (next_st.b_src == sdocr_pkg::SDOCR_SRC_FRAME_REF && !FRAME_REF_ENABLE);

      // input pins
      fmt = r_pin[sdocr_pkg::SDOCR_FMT_LSB +: sdocr_pkg::SDOCR_FMT_W];
      if (fmt > sdocr_pkg::SDOCR_FMT_MAX) begin
         fmt = sdocr_pkg::SDOCR_FMT_CMOS;
      end
      next_st.sync_lvds = fmt[0];
      next_st.req_lvds = fmt[1];
      next_st.hyst = r_pin[sdocr_pkg::SDOCR_HYST_BIT]
         && (fmt != sdocr_pkg::SDOCR_FMT_CMOS);
      next_st.lvl = r_pin[sdocr_pkg::SDOCR_LVL_LSB +: 2];
      if (next_st.lvl == sdocr_pkg::SDOCR_LVL_INVALID) begin
         next_st.lvl = sdocr_pkg::SDOCR_LVL_FULL;
      end
      next_st.sync_used = !r_pin[sdocr_pkg::SDOCR_IGNORE_BIT] && OSCILLATOR_PHASE_ALIGN
         && SYNC_PIN;
      next_st.req_used = !r_pin[sdocr_pkg::SDOCR_IGNORE_BIT] && OSCILLATOR_PHASE_ALIGN
         && FRAME_REF_REQUEST_PIN;
   end

   always_ff @(posedge SYS_CLK) begin
      st <= next_st;
   end

   // ------------------------------------------------------------
   // lock indication
   // ------------------------------------------------------------
   sdocr_lock_timer u_lock (
      .clk(SYS_CLK),
      .reset(RESET),
      .cal_ok(CAL_SUCCESS),
      .tune_ok(TUNE_IN_RANGE),
      .pd_tick(PD_TICK),
      .kind(st.regs[sdocr_pkg::SDOCR_SLOT_LOCK_TYPE][sdocr_pkg::SDOCR_KIND_BIT]),
      .wait_ticks(st.regs[sdocr_pkg::SDOCR_SLOT_LOCK_DELAY]),
      .lock(LOCK_DETECT)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign S_AXI_AWREADY = st.aw_rdy;
   assign S_AXI_WREADY = st.w_rdy;
   assign S_AXI_BRESP = st.bresp;
   assign S_AXI_BVALID = st.bvalid;
   assign S_AXI_ARREADY = st.ar_rdy;
   assign S_AXI_RDATA = st.rdata;
   assign S_AXI_RRESP = st.rresp;
   assign S_AXI_RVALID = st.rvalid;
   assign FEEDBACK_INT = st.fb_int;
   assign DETECTOR_DELAY_SELECT = st.dly_sel;
   assign FRACTION_NUMERATOR = st.num;
   assign FRACTION_DENOMINATOR = st.den;
   assign MODULATOR_SEED = st.seed_out;
   assign MODULATOR_RUN = st.mod_run;
   assign MODULATOR_ORDER = st.order;
   assign OUT_A_POWER_LEVEL = st.a_pwr;
   assign OUT_A_POWERDOWN = st.a_pd;
   assign OUT_A_SOURCE_SELECT = st.a_src;
   assign OUT_A_HIGH_Z = st.a_hiz;
   assign OUTPUT_CURRENT_BOOST = st.boost;
   assign OUT_B_POWER_LEVEL = st.b_pwr;
   assign OUT_B_POWERDOWN = st.b_pd;
   assign OUT_B_SOURCE_SELECT = st.b_src;
   assign OUT_B_HIGH_Z = st.b_hiz;
   assign SYNC_PIN_USED = st.sync_used;
   assign FRAME_REF_REQUEST_USED = st.req_used;
   assign SYNC_LVDS = st.sync_lvds;
   assign REQUEST_LVDS = st.req_lvds;
   assign INPUT_PIN_HYSTERESIS = st.hyst;
   assign INPUT_PIN_BIAS_LEVEL = st.lvl;

endmodule

/* tb/sdocr_regs_assertions.sv */
// checker of the synthesizer configuration register bank
// assumes binding into sdocr_regs, one clock, synchronous reset
`timescale 1ns/1ns
module sdocr_regs_assertions (
   // clock and reset
   input logic SYS_CLK,
   input logic RESET,
   // register bus
   input logic S_AXI_AWVALID,
   input logic S_AXI_AWREADY,
   input logic S_AXI_WVALID,
   input logic S_AXI_WREADY,
   input logic S_AXI_BVALID,
   input logic S_AXI_ARVALID,
   input logic S_AXI_ARREADY,
   input logic S_AXI_RVALID,
   // decoded settings
   input logic [31:0] MODULATOR_SEED,
   input logic MODULATOR_RUN,
   input logic [2:0] MODULATOR_ORDER,
   input logic [1:0] OUT_A_SOURCE_SELECT,
   input logic OUT_A_HIGH_Z,
   input logic [1:0] OUT_B_SOURCE_SELECT,
   input logic OUT_B_HIGH_Z,
   // pins and lock
   input logic OSCILLATOR_PHASE_ALIGN,
   input logic SYNC_PIN,
   input logic SYNC_PIN_USED,
   input logic CAL_SUCCESS,
   input logic LOCK_DETECT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // ------------------------------------------------------------
   // bus answer steps
   // ------------------------------------------------------------
   sequence wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence wr_answer;
      !S_AXI_BVALID ##1 S_AXI_BVALID;
   endsequence
   AST_WR_ANSWER: assert property (wr_taken |-> ##1 wr_answer)
      else $error("late write answer");
   AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("late read answer");
   // ------------------------------------------------------------
   // decoded settings
   // ------------------------------------------------------------
   AST_RUN_GATE: assert property (!MODULATOR_RUN |->
      MODULATOR_SEED == 32'h0 && MODULATOR_ORDER == 3'h0)
      else $error("modulator values pass while held");
   AST_ORDER_CODE: assert property (MODULATOR_ORDER <= 3'h4)
      else $error("reserved order code");
   AST_A_HIGH_Z: assert property (OUT_A_HIGH_Z == (OUT_A_SOURCE_SELECT == 2'h3))
      else $error("output a high-z mismatch");
   AST_B_HIGH_Z: assert property (OUT_B_SOURCE_SELECT != 2'h2 |->
      OUT_B_HIGH_Z == (OUT_B_SOURCE_SELECT == 2'h3))
      else $error("output b high-z mismatch");
   AST_PIN_USE: assert property (SYNC_PIN_USED |->
      $past(OSCILLATOR_PHASE_ALIGN && SYNC_PIN))
      else $error("sync pin use unqualified");
   AST_LOCK_CAL: assert property (LOCK_DETECT |-> $past(CAL_SUCCESS))
      else $error("lock raised without calibration");
endmodule

/* tb/test_sdocr_regs.sv */
// testbench of the synthesizer configuration register bank
// assumes sdocr_pkg, sdocr_regs and the checker compiled before it
`timescale 1ns/1ns
module test_sdocr_regs;
   logic SYS_CLK, RESET, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, FRACTION_NUMERATOR, FRACTION_DENOMINATOR, MODULATOR_SEED;
   logic [3:0] S_AXI_WSTRB;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, OUT_A_SOURCE_SELECT, OUTPUT_CURRENT_BOOST;
   logic [1:0] OUT_B_SOURCE_SELECT, INPUT_PIN_BIAS_LEVEL, rs;
   logic [18:0] FEEDBACK_INT;
   logic [5:0] DETECTOR_DELAY_SELECT, OUT_A_POWER_LEVEL, OUT_B_POWER_LEVEL;
   logic [2:0] MODULATOR_ORDER;
   logic MODULATOR_RUN, FRAME_REF_ENABLE, OUT_A_POWERDOWN, OUT_A_HIGH_Z, OUT_B_POWERDOWN;
   logic OUT_B_HIGH_Z, OSCILLATOR_PHASE_ALIGN, SYNC_PIN, FRAME_REF_REQUEST_PIN, SYNC_PIN_USED;
   logic FRAME_REF_REQUEST_USED, SYNC_LVDS, REQUEST_LVDS, INPUT_PIN_HYSTERESIS;
   logic CAL_SUCCESS, TUNE_IN_RANGE, PD_TICK, LOCK_DETECT;
   logic [31:0] rv;
   int errors, compares;
   localparam logic [21:0] RST_TBL [15] = '{{6'h22, 16'h0000}, {6'h24, 16'h0064},
      {6'h25, 16'h0204}, {6'h26, 16'hffff}, {6'h27, 16'hffff}, {6'h28, 16'h0000},
      {6'h29, 16'h0000}, {6'h2a, 16'h0000}, {6'h2b, 16'h0000}, {6'h2c, 16'h1fa0},
      {6'h2d, 16'hc8df}, {6'h2e, 16'h07fd}, {6'h3a, 16'h8001}, {6'h3b, 16'h0001},
      {6'h3c, 16'h03e8}};
   sdocr_regs DUT (.*);
   // ------------------------------------------------------------
   // checks and bus tasks
   // ------------------------------------------------------------
   task give_verdict;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tmo(input int n);
      if (n >= 60) begin
         errors++;
         $display("ERROR %0t: bus answer timed out", $time);
         give_verdict;
      end
   endtask
   task wr(input logic [5:0] ix, input logic [15:0] d);
      int n;
      n = 0;
      S_AXI_AWADDR <= {ix, 2'h0};
      S_AXI_WDATA <= {16'h0, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         n++;
      end while (!S_AXI_BVALID && n < 60);
      rs = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
      @(posedge SYS_CLK);
      tmo(n);
   endtask
   task rd(input logic [5:0] ix);
      int n;
      n = 0;
      S_AXI_ARADDR <= {ix, 2'h0};
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         n++;
      end while (!S_AXI_RVALID && n < 60);
      rv = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      @(posedge SYS_CLK);
      tmo(n);
   endtask
   task tick;
      PD_TICK <= 1'b1;
      @(posedge SYS_CLK);
      PD_TICK <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
   endtask
   initial begin
      SYS_CLK = 1'b0;
      forever #50 SYS_CLK = ~SYS_CLK;
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      errors = 0;
      compares = 0;
      RESET = 1'b1;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
      {FRAME_REF_ENABLE, OSCILLATOR_PHASE_ALIGN, SYNC_PIN, FRAME_REF_REQUEST_PIN} = '0;
      {CAL_SUCCESS, TUNE_IN_RANGE, PD_TICK} = '0;
      S_AXI_AWADDR = 8'h00;
      S_AXI_ARADDR = 8'h00;
      S_AXI_WDATA = 32'h0;
      S_AXI_WSTRB = 4'hf;
      repeat (16) @(posedge SYS_CLK);
      RESET <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      chk(FEEDBACK_INT, 32'h64);
      chk(FRACTION_DENOMINATOR, 32'hffffffff);
      chk({DETECTOR_DELAY_SELECT, OUT_A_POWER_LEVEL, OUT_B_POWER_LEVEL, OUT_B_POWERDOWN,
         OUT_A_POWERDOWN}, 32'h9f7e);
      for (int i = 0; i < 15; i++) begin
         rd(RST_TBL[i][21:16]);
         chk(rv, {16'h0, RST_TBL[i][15:0]});
      end
      wr(6'h23, 16'h1234);
      chk(rs, 32'h2);
      rd(6'h23);
      chk({rv[29:0], rs}, 32'h2);
      wr(6'h22, 16'hffff);
      wr(6'h24, 16'hffff);
      rd(6'h22);
      chk(rv, 32'h7);
      chk(FEEDBACK_INT, 32'h7ffff);
      wr(6'h2a, 16'h1234);
      wr(6'h2b, 16'h5678);
      chk(FRACTION_NUMERATOR, 32'h12345678);
      wr(6'h29, 16'hffff);
      chk(MODULATOR_SEED, 32'h0);
      wr(6'h25, 16'h8204);
      chk(MODULATOR_SEED, 32'hffff);
      wr(6'h29, 16'h0001);
      chk(MODULATOR_SEED, 32'h10000);
      rd(6'h28);
      chk(rv, 32'h1);
      wr(6'h2c, 16'h2a40);
      chk(MODULATOR_SEED | FRACTION_NUMERATOR | 32'(MODULATOR_RUN), 32'h0);
      chk({OUT_A_POWER_LEVEL, OUT_B_POWERDOWN, OUT_A_POWERDOWN}, 32'ha9);
      for (int i = 0; i < 8; i++) begin
         wr(6'h2c, 16'h1fa0 | 16'(i));
         chk(MODULATOR_ORDER, (i > 4) ? 0 : i);
      end
      chk(MODULATOR_SEED, 32'h0);
      for (int i = 0; i < 8; i++) begin
         FRAME_REF_ENABLE <= i[2];
         wr(6'h2d, 16'hc0df | (16'(i & 3) << 11) | (16'(i & 3) << 9));
         chk({OUT_A_SOURCE_SELECT, OUTPUT_CURRENT_BOOST}, (i & 3) * 5);
         chk(OUT_A_HIGH_Z, (i & 3) == 3);
         wr(6'h2e, 16'h07fc | 16'(i & 3));
         chk(OUT_B_HIGH_Z, (i & 3) == 3 || ((i & 3) == 2 && i < 4));
      end
      for (int i = 0; i < 8; i++) begin
         wr(6'h3a, 16'h4001 | (16'(i) << 9) | (16'(i & 3) << 12));
         chk({SYNC_LVDS, REQUEST_LVDS}, (i < 4) ? {i[0], i[1]} : 0);
         chk(INPUT_PIN_HYSTERESIS, i > 0 && i < 4);
         chk(INPUT_PIN_BIAS_LEVEL, ((i & 3) == 3) ? 1 : (i & 3));
      end
      OSCILLATOR_PHASE_ALIGN <= 1'b1;
      SYNC_PIN <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      chk({SYNC_PIN_USED, FRAME_REF_REQUEST_USED}, 32'h2);
      wr(6'h3a, 16'h8001);
      repeat (2) @(posedge SYS_CLK);
      chk(SYNC_PIN_USED, 32'h0);
      wr(6'h3c, 16'h0003);
      CAL_SUCCESS <= 1'b1;
      repeat (4) tick;
      chk(LOCK_DETECT, 32'h0);
      TUNE_IN_RANGE <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      repeat (2) tick;
      chk(LOCK_DETECT, 32'h0);
      tick;
      chk(LOCK_DETECT, 32'h1);
      give_verdict;
   end
endmodule
bind sdocr_regs sdocr_regs_assertions u_chk (.*);
